// ===== core/ddsl_device.sv
// synthesizer end: input register, update commit, reset and core
`timescale 1ns/10ps
`include "ddsl_regs.svh"
module ddsl_device
  import ddsl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  ddsl_if.device link,
  input wire logic serial_mode,
  output logic [13:0] dds_phase,
  output logic [31:0] active_freq,
  output logic [4:0] active_phase,
  output logic power_down,
  output logic core_ready
);
  ddsl_dev_t r;
  ddsl_dev_t next_r;
  logic ref_tick;
  logic load_rise;
  logic upd_rise;
  logic rst_lvl;
  logic take_update;
  logic lat_run;
  logic out_hold;

  // a pin level counts only once the second and third stages agree
  function automatic logic [11:0] agree(input logic [11:0] second,
                                        input logic [11:0] third,
                                        input logic [11:0] lvl);
    agree = (~(second ^ third) & second) | ((second ^ third) & lvl);
  endfunction

  always_comb begin
    next_r = r;
    // the first stage is read by the second stage only
    next_r.sy0 = {link.ref_sample_clock, link.word_load_strobe,
                  link.update_strobe, link.master_reset,
                  link.load_byte_bus};
    next_r.sy1 = r.sy0;
    next_r.sy2 = r.sy1;
    next_r.lvl = agree(r.sy1, r.sy2, r.lvl);
    ref_tick = next_r.lvl[`DDSL_PIN_REF] & ~r.lvl[`DDSL_PIN_REF];
    load_rise = next_r.lvl[`DDSL_PIN_LOAD] & ~r.lvl[`DDSL_PIN_LOAD];
    upd_rise = next_r.lvl[`DDSL_PIN_UPD] & ~r.lvl[`DDSL_PIN_UPD];
    rst_lvl = next_r.lvl[`DDSL_PIN_RST];
    take_update = upd_rise && (r.st != dev_reset)
                  && (r.st != dev_recover);
    lat_run = ref_tick && (r.st != dev_reset) && (r.st != dev_recover);
    // an accepted reset keeps its output latency past an early release
    out_hold = (r.rcnt >= `DDSL_RST_ACCEPT)
               && (r.rcnt != `DDSL_RST_OUT_LAT);

    // input register keeps loading even while reset is held
    if (load_rise) begin
      if (serial_mode) begin
        // first bit ends in bit 0, the control byte arrives last
        next_r.input_reg = {next_r.lvl[`DDSL_SERIAL_BIT],
                            r.input_reg[39:1]};
      end else if (r.ptr < `DDSL_NUM_WORDS) begin
        next_r.input_reg[8 * (4 - int'(r.ptr)) +: 8] =
          next_r.lvl[7:0];
        next_r.ptr = r.ptr + 3'h1;
      end
    end

    // pending words wait out their latency on reference ticks
    if (lat_run) begin
      if (r.freq_cnt != 5'h00) begin
        next_r.freq_cnt = r.freq_cnt - 5'h01;
        if (r.freq_cnt == 5'h01) begin
          next_r.freq = r.freq_pend;
        end
      end
      if (r.phase_cnt != 5'h00) begin
        next_r.phase_cnt = r.phase_cnt - 5'h01;
        if (r.phase_cnt == 5'h01) begin
          next_r.phase = r.phase_pend;
          next_r.pd = r.pd_pend;
        end
      end
    end

    // a later update restarts the wait and the whole words replace
    if (take_update) begin
      next_r.freq_pend = r.input_reg[31:0];
      next_r.phase_pend = r.input_reg[39:`DDSL_PHASE_LSB];
      next_r.pd_pend = r.input_reg[`DDSL_PD_BIT];
      next_r.freq_cnt = `DDSL_FREQ_LAT;
      next_r.phase_cnt = `DDSL_PHASE_LAT;
      next_r.ptr = 3'h0;
    end

    // reset latency counts in reset and runs on through recovery
    if (ref_tick && (r.rcnt != `DDSL_RST_OUT_LAT)
        && ((r.st == dev_reset) || out_hold)) begin
      next_r.rcnt = r.rcnt + 4'h1;
      if (r.rcnt + 4'h1 == `DDSL_RST_ACCEPT) begin
        // everything but the input register and the output, which waits out the output latency
        next_r.ptr = 3'h0;
        next_r.freq = 32'h0000_0000;
        next_r.freq_pend = 32'h0000_0000;
        next_r.phase = 5'h00;
        next_r.phase_pend = 5'h00;
        next_r.pd_pend = 1'b0;
        next_r.freq_cnt = 5'h00;
        next_r.phase_cnt = 5'h00;
        next_r.pd = 1'b0;
        next_r.acc = 32'h0000_0000;
      end
      if (r.rcnt + 4'h1 == `DDSL_RST_OUT_LAT) begin
        next_r.out = 14'h0000;
      end
    end

    case (r.st)
      dev_run: begin
        if (ref_tick) begin
          next_r.acc = r.acc + r.freq;
          // old output stands until the reset latency has run out
          if (!out_hold) begin
            next_r.out = r.acc[31:18] + {r.phase, 9'h000};
          end
        end
        if (next_r.pd) begin
          next_r.st = dev_down;
        end
      end
      dev_down: begin
        // accumulator frozen while powered down
        if (!next_r.pd) begin
          next_r.wcnt = 11'h000;
          next_r.st = dev_wake;
        end
      end
      dev_wake: begin
        next_r.wcnt = r.wcnt + 11'h001;
        if (r.wcnt == 11'(`DDSL_WAKE_CYC - 1)) begin
          next_r.st = dev_run;
        end
        if (next_r.pd) begin
          next_r.st = dev_down;
        end
      end
      dev_reset: begin
        if (!rst_lvl) begin
          next_r.wcnt = 11'h000;
          // a pulse shorter than the least width is not accepted
          if (next_r.rcnt >= `DDSL_RST_ACCEPT) begin
            next_r.st = dev_recover;
          end else begin
            next_r.rcnt = 4'h0;
            next_r.st = r.pd ? dev_down : dev_run;
          end
        end
      end
      dev_recover: begin
        // wake counter is free here, the reset count is still in use
        if (ref_tick) begin
          next_r.wcnt = r.wcnt + 11'h001;
          if (r.wcnt + 11'h001 == {7'h00, `DDSL_RECOVER}) begin
            next_r.st = dev_run;
          end
        end
      end
      default: begin
        next_r.st = dev_run;
      end
    endcase

    // reset entry takes priority over every other state move
    if (rst_lvl && (r.st != dev_reset)) begin
      next_r.rcnt = 4'h0;
      next_r.st = dev_reset;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: dev_run, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign dds_phase = r.out;
  assign active_freq = r.freq;
  assign active_phase = r.phase;
  assign power_down = r.pd;
  assign core_ready = (r.st == dev_run);
endmodule

// ===== core/ddsl_host.sv
// controller end: makes the reference clock, loads words, resets
`timescale 1ns/10ps
`include "ddsl_regs.svh"
module ddsl_host
  import ddsl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  ddsl_if.host link,
  input wire logic load_start,
  input wire logic reset_start,
  input wire logic serial_mode,
  input wire logic [31:0] freq_in,
  input wire logic [7:0] ctrl_in,
  output logic busy
);
  ddsl_host_t r;
  ddsl_host_t next_r;

  function automatic logic step_done(input logic [5:0] cnt,
                                     input logic [5:0] lim);
    step_done = (cnt == lim - 6'h01);
  endfunction

  always_comb begin
    next_r = r;
    next_r.cnt = r.cnt + 6'h01;
    // free-running divider: the far end only samples this clock
    next_r.div = r.div + 3'h1;
    if (r.div == `DDSL_REF_HALF - 3'h1) begin
      next_r.div = 3'h0;
      next_r.ref_clk = ~r.ref_clk;
    end
    case (r.st)
      host_idle: begin
        next_r.cnt = 6'h00;
        if (reset_start) begin
          next_r.rst = 1'b1;
          next_r.st = host_rst_hold;
        end else if (load_start) begin
          next_r.word = {ctrl_in, freq_in};
          next_r.ser = serial_mode;
          next_r.idx = 6'h00;
          next_r.st = host_setup;
        end
      end
      host_setup: begin
        // serial data rides on bit 7 only, the other lines stay low
        next_r.bus = r.ser ? {r.word[0], 7'h00} : r.word[39:32];
        if (step_done(r.cnt, `DDSL_STEP)) begin
          next_r.load = 1'b1;
          next_r.cnt = 6'h00;
          next_r.st = host_high;
        end
      end
      host_high: begin
        if (step_done(r.cnt, `DDSL_STEP)) begin
          next_r.load = 1'b0;
          next_r.cnt = 6'h00;
          next_r.st = host_low;
        end
      end
      host_low: begin
        if (step_done(r.cnt, `DDSL_STEP)) begin
          next_r.cnt = 6'h00;
          next_r.idx = r.idx + 6'h01;
          next_r.word = r.ser ? {1'b0, r.word[39:1]} : {r.word[31:0], 8'h00};
          if (r.idx + 6'h01 == (r.ser ? `DDSL_SERIAL_BITS
                                       : {3'h0, `DDSL_NUM_WORDS})) begin
            next_r.upd = 1'b1;
            next_r.st = host_upd_hi;
          end else begin
            next_r.st = host_setup;
          end
        end
      end
      host_upd_hi: begin
        if (step_done(r.cnt, `DDSL_STEP)) begin
          next_r.upd = 1'b0;
          next_r.cnt = 6'h00;
          next_r.st = host_upd_lo;
        end
      end
      host_upd_lo: begin
        if (step_done(r.cnt, `DDSL_STEP)) begin
          next_r.st = host_idle;
        end
      end
      host_rst_hold: begin
        // one reference period of margin beyond the least width
        if (step_done(r.cnt, `DDSL_RST_HOLD)) begin
          next_r.rst = 1'b0;
          next_r.cnt = 6'h00;
          next_r.st = host_rst_wait;
        end
      end
      host_rst_wait: begin
        if (step_done(r.cnt, `DDSL_RECOVER_WAIT)) begin
          next_r.st = host_idle;
        end
      end
      default: begin
        next_r.st = host_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: host_idle, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign busy = (r.st != host_idle);
  assign link.ref_sample_clock = r.ref_clk;
  assign link.word_load_strobe = r.load;
  assign link.update_strobe = r.upd;
  assign link.master_reset = r.rst;
  assign link.load_byte_bus = r.bus;
endmodule

// ===== include/ddsl_if.sv
// pins between the controller and the synthesizer word-load port
`timescale 1ns/10ps
interface ddsl_if;
  logic ref_sample_clock;
  logic word_load_strobe;
  logic update_strobe;
  logic master_reset;
  logic [7:0] load_byte_bus;
  modport device (
    input ref_sample_clock,
    input word_load_strobe,
    input update_strobe,
    input master_reset,
    input load_byte_bus
  );
  modport host (
    output ref_sample_clock,
    output word_load_strobe,
    output update_strobe,
    output master_reset,
    output load_byte_bus
  );
endinterface

// ===== include/ddsl_pkg.sv
// state types of both ends of the word-load port
package ddsl_pkg;
  typedef enum logic [4:0] {
    dev_run = 5'h01,
    dev_down = 5'h02,
    dev_wake = 5'h04,
    dev_reset = 5'h08,
    dev_recover = 5'h10
  } ddsl_dev_state_t;

  typedef struct packed {
    logic [11:0] sy0;
    logic [11:0] sy1;
    logic [11:0] sy2;
    logic [11:0] lvl;
    ddsl_dev_state_t st;
    logic [39:0] input_reg;
    logic [2:0] ptr;
    logic [31:0] freq;
    logic [31:0] freq_pend;
    logic [4:0] phase;
    logic [4:0] phase_pend;
    logic pd_pend;
    logic [4:0] freq_cnt;
    logic [4:0] phase_cnt;
    logic pd;
    logic [31:0] acc;
    logic [13:0] out;
    logic [3:0] rcnt;
    logic [10:0] wcnt;
  } ddsl_dev_t;

  typedef enum logic [7:0] {
    host_idle = 8'h01,
    host_setup = 8'h02,
    host_high = 8'h04,
    host_low = 8'h08,
    host_upd_hi = 8'h10,
    host_upd_lo = 8'h20,
    host_rst_hold = 8'h40,
    host_rst_wait = 8'h80
  } ddsl_host_state_t;

  typedef struct packed {
    ddsl_host_state_t st;
    logic [5:0] cnt;
    logic [2:0] div;
    logic ref_clk;
    logic load;
    logic upd;
    logic rst;
    logic [7:0] bus;
    logic [39:0] word;
    logic [5:0] idx;
    logic ser;
  } ddsl_host_t;
endpackage

// ===== include/ddsl_regs.svh
// timing counts, field positions and pin positions of the word-load port
`ifndef DDSL_REGS_SVH
`define DDSL_REGS_SVH
`define DDSL_FREQ_LAT 5'd18
`define DDSL_PHASE_LAT 5'd13
`define DDSL_RST_ACCEPT 4'd5
`define DDSL_RST_OUT_LAT 4'd13
`define DDSL_RECOVER 4'd2
`define DDSL_WAKE_NS 5000
`define DDSL_CLK_NS 4
`define DDSL_WAKE_CYC (`DDSL_WAKE_NS / `DDSL_CLK_NS)
`define DDSL_PIN_REF 11
`define DDSL_PIN_LOAD 10
`define DDSL_PIN_UPD 9
`define DDSL_PIN_RST 8
`define DDSL_SERIAL_BIT 7
`define DDSL_PD_BIT 34
`define DDSL_PHASE_LSB 35
`define DDSL_NUM_WORDS 3'd5
`define DDSL_SERIAL_BITS 6'd40
`define DDSL_REF_HALF 3'd4
`define DDSL_STEP 6'd4
`define DDSL_RST_HOLD 6'd48
`define DDSL_RECOVER_WAIT 6'd24
`endif

// ===== test/ddsl_properties.sv
// concurrent checks on the word-load port pins between the two ends
`timescale 1ns/10ps
module ddsl_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ref_sample_clock,
  input wire logic word_load_strobe,
  input wire logic update_strobe,
  input wire logic master_reset,
  input wire logic [7:0] load_byte_bus
);
  logic [7:0] rst_len;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // saturates so a long hold never wraps back under the minimum
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_len <= 8'h00;
    end else if (!master_reset) begin
      rst_len <= 8'h00;
    end else if (rst_len != 8'hFF) begin
      rst_len <= rst_len + 8'h01;
    end
  end

  sequence upd_pulse;
    update_strobe [*4] ##1 !update_strobe [*4];
  endsequence

  sequence quiet_pins;
    (!word_load_strobe && !update_strobe) [*8];
  endsequence

  a_ref_high_phase: assert property (
    $rose(ref_sample_clock) |-> ref_sample_clock [*4] ##1 !ref_sample_clock)
    else $error("reference clock high phase wrong");
  a_ref_low_phase: assert property (
    $fell(ref_sample_clock) |-> !ref_sample_clock [*4] ##1 ref_sample_clock)
    else $error("reference clock low phase wrong");
  a_reset_min_hold: assert property (
    $fell(master_reset) |-> rst_len >= 8'h28)
    else $error("master reset released too early");
  a_load_pulse_width: assert property (
    $rose(word_load_strobe) |-> word_load_strobe [*4] ##1 !word_load_strobe)
    else $error("load strobe width wrong");
  a_load_bus_stable: assert property (
    word_load_strobe |-> $stable(load_byte_bus))
    else $error("load bus moved under the strobe");
  a_update_pulse_shape: assert property (
    $rose(update_strobe) |-> upd_pulse)
    else $error("update strobe shape wrong");
  a_update_alone: assert property (
    update_strobe |-> !word_load_strobe && !master_reset)
    else $error("update overlaps load or reset");
  a_reset_recovery_quiet: assert property (
    $fell(master_reset) |-> quiet_pins)
    else $error("activity during reset recovery");
  a_update_after_load: assert property (
    $rose(update_strobe) |-> !$past(word_load_strobe, 4))
    else $error("update too close to load strobe");
endmodule

// ===== test/test_dds_tuning_word_load_port.sv
// self-checking bench: controller end facing synthesizer end
`timescale 1ns/10ps
module test_dds_tuning_word_load_port
  import ddsl_pkg::*;
;
  logic clock, reset_n, load_start, reset_start, serial, busy;
  logic [31:0] freq_in, active_freq;
  logic [7:0] ctrl_in;
  logic [13:0] dds_phase, p1;
  logic [4:0] active_phase;
  logic power_down, core_ready;
  int fails, checks;

  ddsl_if u_ddsl_if ();
  ddsl_host u_ddsl_host (.clock(clock), .reset_n(reset_n), .link(u_ddsl_if),
    .load_start(load_start), .reset_start(reset_start),
    .serial_mode(serial), .freq_in(freq_in), .ctrl_in(ctrl_in), .busy(busy));
  ddsl_device u_ddsl_device (.clock(clock), .reset_n(reset_n),
    .link(u_ddsl_if), .serial_mode(serial), .dds_phase(dds_phase),
    .active_freq(active_freq), .active_phase(active_phase),
    .power_down(power_down), .core_ready(core_ready));
  ddsl_properties u_ddsl_properties (.clock(clock), .reset_n(reset_n),
    .ref_sample_clock(u_ddsl_if.ref_sample_clock),
    .word_load_strobe(u_ddsl_if.word_load_strobe),
    .update_strobe(u_ddsl_if.update_strobe),
    .master_reset(u_ddsl_if.master_reset),
    .load_byte_bus(u_ddsl_if.load_byte_bus));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic finish_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // a used-up wait ends the run rather than piling up later mismatches
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      finish_test();
    end
  endtask

  task automatic load(input logic [31:0] f, input logic [7:0] c,
                      input logic s);
    int n;
    @(negedge clock);
    freq_in = f;
    ctrl_in = c;
    serial = s;
    load_start = 1'b1;
    @(negedge clock);
    load_start = 1'b0;
    @(negedge clock);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clock);
    bound(n, 3000);
  endtask

  // phase lands 13 reference ticks after update, frequency 5 ticks later
  task automatic load_check(input logic [31:0] f, input logic [7:0] c,
                            input logic s);
    int n, cp, cf;
    load(f, c, s);
    cp = 0;
    cf = 0;
    for (n = 1; n < 200; n++) begin
      @(negedge clock);
      if (cp == 0 && active_phase === c[7:3]) cp = n;
      if (cf == 0 && active_freq === f) cf = n;
    end
    check(cf - cp, 40);
    check(cp > 80 && cp < 112, 1);
    check(active_freq, f);
    check(active_phase, c[7:3]);
  endtask

  task automatic t_parallel();
    load_check(32'h12345678, 8'h58, 1'b0);
  endtask

  task automatic t_serial();
    load_check(32'hA5C40000, 8'hA3, 1'b1);
    // samples 8 clocks apart always straddle exactly one tick
    p1 = dds_phase;
    repeat (8) @(negedge clock);
    check(14'(dds_phase - p1), 14'h2971);
    load_check(32'h0F1E2D3C, 8'h90, 1'b0);
  endtask

  task automatic t_power();
    int n;
    load(32'h00010000, 8'h54, 1'b0);
    repeat (120) @(negedge clock);
    check(power_down, 1'b1);
    check(core_ready, 1'b0);
    p1 = dds_phase;
    repeat (16) @(negedge clock);
    check(dds_phase, p1);
    load(32'h00010000, 8'h50, 1'b0);
    for (n = 0; n < 200 && power_down !== 1'b0; n++) @(negedge clock);
    bound(n, 200);
    for (n = 0; n < 1400 && core_ready !== 1'b1; n++) @(negedge clock);
    check(n >= 1200 && n <= 1251, 1);
  endtask

  task automatic t_reset();
    int n, nr, nc, nz;
    @(negedge clock);
    reset_start = 1'b1;
    @(negedge clock);
    reset_start = 1'b0;
    nr = 0;
    nc = 0;
    nz = 0;
    // release and recovery fall inside the output latency: watch all
    for (n = 1; n < 200; n++) begin
      @(negedge clock);
      if (nr == 0 && u_ddsl_if.master_reset === 1'b0) nr = n;
      if (nr != 0 && nc == 0 && core_ready === 1'b1) nc = n;
      if (nz == 0 && dds_phase === 14'h0000) nz = n;
    end
    check(nz >= 92 && nz <= 116, 1);
    bound(nr == 0, 1);
    check(nc - nr >= 12 && nc - nr <= 32, 1);
    repeat (16) @(negedge clock);
    check(active_freq, 32'h00000000);
    check(active_phase, 5'h00);
    check(power_down, 1'b0);
  endtask

  initial begin
    reset_n = 1'b0;
    load_start = 1'b0;
    reset_start = 1'b0;
    serial = 1'b0;
    freq_in = 32'h00000000;
    ctrl_in = 8'h00;
    fails = 0;
    checks = 0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    check(core_ready, 1'b1);
    t_parallel();
    t_serial();
    t_power();
    t_reset();
    finish_test();
  end
endmodule
